//--- verilog/rx_step_config.sv
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rx_step_consts.svh"
module rx_step_config #(
   parameter int TICK_CYCLES = `RSF_TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic link_clk,
   input wire logic link_sel_n,
   input wire logic link_data,
   input wire logic battery_low_input,
   input wire logic [6:0] frame_query,
   input wire logic [2:0] air_collapse,
   output logic [7:0] receiver_control_lines,
   output logic receiver_control_oe_n,
   output logic symbols_valid,
   output logic frame_is_assigned,
   output logic [15:0] address_word_enable
);

   ////////////////////////////////////////////////////////////////////////
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic link_clk_prev_q;
   logic [31:0] shift_q;
   logic [5:0] bit_cnt_q;
   logic link_pkt_q;
   logic [31:0] pkt;
   logic [2:0] on_slot;
   logic pkt_valid;
   logic aw_full_q, w_full_q, aw_full_d, w_full_d;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;
   logic [3:0] ctrl_q;
   logic [31:0] last_pkt_q;
   logic [7:0] line_setting_value [0:`RSF_SLOTS-1];
   logic battery_check_on_exit [0:`RSF_SLOTS-1];
   logic [6:0] step_duration [0:`RSF_SLOTS-1];
   logic [1:0] step_enable_flag;
   logic [127:0] frame_assigned_bits;
   logic manual_collapse_select;
   rx_step_pkg::rx_state_type state_q, state_d;
   logic on_prev_q;
   logic [16:0] tick_cnt_q;
   logic [6:0] step_cnt_q;
   logic tick_end, step_done, leaving;
   logic battery_low_q;

   assign manual_collapse_select = ctrl_q[`RSF_CTL_MANUAL];

   function automatic logic [2:0] slot_of(rx_step_pkg::rx_state_type s,
                                          logic [1:0] sel);
      case (s)
         rx_step_pkg::RX_SYNC: slot_of = `RSF_SLOT_SYNC;
         rx_step_pkg::RX_ON: slot_of = `RSF_SLOT_ON0 + {1'b0, sel};
         rx_step_pkg::RX_SHUT1: slot_of = `RSF_SLOT_SD1;
         rx_step_pkg::RX_SHUT2: slot_of = `RSF_SLOT_SD2;
         default: slot_of = `RSF_SLOT_SYNC;
      endcase
   endfunction : slot_of

   // Collapse c widens the match to every frame sharing the low c bits.
   function automatic logic frame_hit(logic [127:0] af, logic [6:0] f,
                                      logic [2:0] c, logic manual);
      logic [6:0] mask;
      logic hit;
      mask = 7'h7F;
      hit = 1'b0;
      if (!manual && c != 3'h7) begin
         mask = 7'((8'h01 << c) - 8'h01);
      end
      for (int j = 0; j < 128; j++) begin
         if (((7'(j) ^ f) & mask) == 7'h00 && af[j]) begin
            hit = 1'b1;
         end
      end
      frame_hit = hit;
   endfunction : frame_hit

   ////////////////////////////////////////////////////////////////////////
   // Pins pass two flops; only the second stage is read.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else begin
         sync1_q <= {battery_low_input, link_data, link_sel_n, link_clk};
         sync2_q <= sync1_q;
      end
   end

   // Serial packets arrive MSB first, sampled on rising link clock.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_clk_prev_q <= 1'b0;
         shift_q <= 32'h0000_0000;
         bit_cnt_q <= 6'h00;
         link_pkt_q <= 1'b0;
      end else begin
         link_clk_prev_q <= sync2_q[0];
         link_pkt_q <= 1'b0;
         if (sync2_q[1]) begin
            bit_cnt_q <= 6'h00;
         end else if (sync2_q[0] && !link_clk_prev_q) begin
            shift_q <= {shift_q[30:0], sync2_q[2]};
            if (bit_cnt_q == `RSF_PKT_BITS - 6'h01) begin
               bit_cnt_q <= 6'h00;
               link_pkt_q <= 1'b1;
            end else begin
               bit_cnt_q <= bit_cnt_q + 6'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // A packet write over the bus waits while a link packet is delivered.
   assign do_write = aw_full_q && w_full_q && !s_axi_bvalid && !link_pkt_q;

   always_comb begin
      aw_full_d = aw_full_q;
      w_full_d = w_full_q;
      if (do_write) begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
      end
      if (s_axi_awvalid && s_axi_awready) begin
         aw_full_d = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_full_d = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         ctrl_q <= 4'h0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         s_axi_awready <= !aw_full_d;
         s_axi_wready <= !w_full_d;
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            case (awaddr_q)
               `RSF_OFF_PACKET: ;
               `RSF_OFF_CONTROL: if (wstrb_q[0]) begin
                  ctrl_q <= wdata_q[3:0];
               end
               `RSF_OFF_STATUS, `RSF_OFF_ADDR_EN, `RSF_OFF_LAST_PKT: ;
               default: s_axi_bresp <= 2'h2;
            endcase
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign pkt_valid = link_pkt_q ||
      (do_write && awaddr_q == `RSF_OFF_PACKET && wstrb_q == 4'hF);
   assign pkt = link_pkt_q ? shift_q : wdata_q;
   // On identifiers 0x17 to 0x19 land in slots one to three.
   assign on_slot = 3'(pkt[27:24] - 4'h6);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
               `RSF_OFF_CONTROL: s_axi_rdata <= {28'h000_0000, ctrl_q};
               `RSF_OFF_STATUS: s_axi_rdata <= {27'h000_0000,
                  battery_low_q, symbols_valid, state_q};
               `RSF_OFF_ADDR_EN:
                  s_axi_rdata <= {16'h0000, address_word_enable};
               `RSF_OFF_LAST_PKT: s_axi_rdata <= last_pkt_q;
               `RSF_OFF_PACKET: s_axi_rdata <= 32'h0000_0000;
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < `RSF_SLOTS; i++) begin
            line_setting_value[i] <= `RSF_RST_CLS;
            battery_check_on_exit[i] <= 1'b0;
            step_duration[i] <= `RSF_RST_STEP;
         end
         step_enable_flag <= 2'h0;
         frame_assigned_bits <= 128'h0;
         address_word_enable <= 16'h0000;
         last_pkt_q <= 32'h0000_0000;
      end else if (pkt_valid) begin
         last_pkt_q <= pkt;
         if (pkt[31:24] == `RSF_ID_SYNC3200) begin
            line_setting_value[`RSF_SLOT_SYNC] <= pkt[15:8];
            battery_check_on_exit[`RSF_SLOT_SYNC] <= pkt[`RSF_BIT_LBC];
            step_duration[`RSF_SLOT_SYNC] <= pkt[6:0];
         end else if (pkt[31:24] >= `RSF_ID_ON_FIRST &&
                      pkt[31:24] <= `RSF_ID_ON_LAST) begin
            // On settings keep their step time at reset value.
            line_setting_value[on_slot] <= pkt[15:8];
            battery_check_on_exit[on_slot] <= pkt[`RSF_BIT_LBC];
         end else if (pkt[31:24] == `RSF_ID_SHUT1 ||
                      pkt[31:24] == `RSF_ID_SHUT2) begin
            // Bit 24 picks step one or two.
            line_setting_value[`RSF_SLOT_SD1 + {2'h0, pkt[24]}] <=
               pkt[15:8];
            battery_check_on_exit[`RSF_SLOT_SD1 + {2'h0, pkt[24]}] <=
               pkt[`RSF_BIT_LBC];
            step_duration[`RSF_SLOT_SD1 + {2'h0, pkt[24]}] <=
               {1'b0, pkt[5:0]};
            step_enable_flag[pkt[24]] <= pkt[`RSF_BIT_SE];
         end else if (pkt[31:24] >= `RSF_ID_FRAME_LO &&
                      pkt[31:24] <= `RSF_ID_FRAME_HI) begin
            // Code k holds frames 127-16k down to 112-16k.
            frame_assigned_bits[(7 - pkt[26:24]) * 16 +: 16] <= pkt[15:0];
         end else if (pkt[31:24] == `RSF_ID_ADDR_EN) begin
            // Bit n gates address word 128+n.
            address_word_enable <= pkt[15:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_is_assigned <= 1'b0;
      end else begin
         frame_is_assigned <= frame_hit(frame_assigned_bits, frame_query,
            air_collapse, manual_collapse_select);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // A step of code 0 is treated as one tick.
   assign tick_end = tick_cnt_q == 17'(TICK_CYCLES - 1);
   assign step_done = tick_end && (step_cnt_q + 7'h01 >=
      step_duration[slot_of(state_q, ctrl_q[3:2])]);

   always_comb begin
      state_d = state_q;
      case (state_q)
         rx_step_pkg::RX_OFF: if (ctrl_q[`RSF_CTL_ON] && !on_prev_q) begin
            state_d = rx_step_pkg::RX_SYNC;
         end
         rx_step_pkg::RX_SYNC: if (step_done) begin
            state_d = rx_step_pkg::RX_ON;
         end
         rx_step_pkg::RX_ON: if (!ctrl_q[`RSF_CTL_ON]) begin
            state_d = step_enable_flag[0] ? rx_step_pkg::RX_SHUT1 :
               rx_step_pkg::RX_OFF;
         end
         rx_step_pkg::RX_SHUT1: if (step_done) begin
            state_d = step_enable_flag[1] ? rx_step_pkg::RX_SHUT2 :
               rx_step_pkg::RX_OFF;
         end
         rx_step_pkg::RX_SHUT2: if (step_done) begin
            state_d = rx_step_pkg::RX_OFF;
         end
         default: state_d = rx_step_pkg::RX_OFF;
      endcase
   end

   assign leaving = state_d != state_q && state_q != rx_step_pkg::RX_OFF;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= rx_step_pkg::RX_OFF;
         on_prev_q <= 1'b0;
         tick_cnt_q <= 17'h0_0000;
         step_cnt_q <= 7'h00;
      end else begin
         state_q <= state_d;
         on_prev_q <= ctrl_q[`RSF_CTL_ON];
         if (state_d != state_q || tick_end) begin
            tick_cnt_q <= 17'h0_0000;
         end else begin
            tick_cnt_q <= tick_cnt_q + 17'h0_0001;
         end
         if (state_d != state_q) begin
            step_cnt_q <= 7'h00;
         end else if (tick_end) begin
            step_cnt_q <= step_cnt_q + 7'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         battery_low_q <= 1'b0;
      end else if (leaving &&
                   battery_check_on_exit[slot_of(state_q, ctrl_q[3:2])]) begin
         battery_low_q <= sync2_q[3];
      end
   end

   // Lines are released during reset and driven from then on.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receiver_control_lines <= 8'h00;
         receiver_control_oe_n <= 1'b1;
         symbols_valid <= 1'b0;
      end else begin
         receiver_control_oe_n <= 1'b0;
         receiver_control_lines <= state_d == rx_step_pkg::RX_OFF ? 8'h00 :
            line_setting_value[slot_of(state_d, ctrl_q[3:2])];
         symbols_valid <= state_d == rx_step_pkg::RX_ON;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence sync_ends;
      state_q == rx_step_pkg::RX_SYNC && step_done;
   endsequence

   sequence on_entered;
      state_q == rx_step_pkg::RX_ON && symbols_valid;
   endsequence

   a_reset_float: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> receiver_control_oe_n)
      else $error("lines driven in reset");
   a_sync_to_on: assert property (sync_ends |=> on_entered)
      else $error("sync step did not end in on state");
   a_valid_only_on: assert property (symbols_valid |->
      state_q == rx_step_pkg::RX_ON) else $error("early symbols");
   a_sync_hold_time: assert property (sync_ends |->
      step_cnt_q + 7'h01 >= step_duration[`RSF_SLOT_SYNC])
      else $error("sync step left too soon");
   a_shut_skip_all: assert property (
      state_q == rx_step_pkg::RX_ON && !ctrl_q[`RSF_CTL_ON] &&
      !step_enable_flag[0] |=> state_q == rx_step_pkg::RX_OFF)
      else $error("disabled first shut-down step not skipped");
   a_shut_second_skip: assert property (
      state_q == rx_step_pkg::RX_SHUT1 && step_done &&
      !step_enable_flag[1] |=> state_q == rx_step_pkg::RX_OFF)
      else $error("disabled second shut-down step not skipped");
   a_lines_follow_sd1: assert property (
      state_q == rx_step_pkg::RX_SHUT1 && $stable(state_q) |->
      receiver_control_lines == $past(line_setting_value[`RSF_SLOT_SD1]))
      else $error("lines differ from shut-down setting");
   a_battery_sample: assert property (leaving &&
      battery_check_on_exit[slot_of(state_q, ctrl_q[3:2])] |=>
      battery_low_q == $past(sync2_q[3]))
      else $error("battery input not sampled on exit");
   a_frame_group: assert property (pkt_valid &&
      pkt[31:24] == `RSF_ID_FRAME_LO |=>
      frame_assigned_bits[127:112] == $past(pkt[15:0]))
      else $error("frame group zero misplaced");
   a_addr_enable: assert property (pkt_valid &&
      pkt[31:24] == `RSF_ID_ADDR_EN |=>
      address_word_enable == $past(pkt[15:0]))
      else $error("address enables not stored");
   a_manual_frame: assert property (manual_collapse_select
      |=> frame_is_assigned == $past(frame_assigned_bits[frame_query]))
      else $error("manual collapse altered frame match");
   a_tick_wrap: assert property (tick_end && state_d == state_q |=>
      tick_cnt_q == 17'h0_0000) else $error("tick counter did not wrap");

endmodule : rx_step_config

//--- verilog/rx_step_consts.svh
`ifndef RX_STEP_CONSTS_SVH
`define RX_STEP_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define RSF_OFF_PACKET 8'h00
`define RSF_OFF_CONTROL 8'h04
`define RSF_OFF_STATUS 8'h08
`define RSF_OFF_ADDR_EN 8'h0C
`define RSF_OFF_LAST_PKT 8'h10

// Control register fields.
`define RSF_CTL_ON 0
`define RSF_CTL_MANUAL 1
`define RSF_CTL_SEL_LO 2
`define RSF_CTL_SEL_HI 3

// Packet identifiers and field positions.
`define RSF_ID_SYNC3200 8'h16
`define RSF_ID_ON_FIRST 8'h17
`define RSF_ID_ON_LAST 8'h19
`define RSF_ID_SHUT1 8'h1A
`define RSF_ID_SHUT2 8'h1B
`define RSF_ID_FRAME_LO 8'h20
`define RSF_ID_FRAME_HI 8'h27
`define RSF_ID_ADDR_EN 8'h78
`define RSF_BIT_SE 23
`define RSF_BIT_LBC 19

// Setting slots: sync, three on settings, two shut-down steps.
`define RSF_SLOT_SYNC 3'h0
`define RSF_SLOT_ON0 3'h1
`define RSF_SLOT_SD1 3'h4
`define RSF_SLOT_SD2 3'h5
`define RSF_SLOTS 6

// Reset values.
`define RSF_RST_STEP 7'h01
`define RSF_RST_CLS 8'h00

// Timing.
`define RSF_TICK_US 625
`define RSF_CLK_MHZ 100
`define RSF_TICK_CYCLES (`RSF_TICK_US * `RSF_CLK_MHZ)
`define RSF_PKT_BITS 6'h20

`endif

//--- verilog/rx_step_pkg.sv
package rx_step_pkg;

   typedef enum logic [2:0] {
      RX_OFF = 3'h0,
      RX_SYNC = 3'h1,
      RX_ON = 3'h3,
      RX_SHUT1 = 3'h2,
      RX_SHUT2 = 3'h6
   } rx_state_type;

endpackage : rx_step_pkg

//--- verif/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
   output logic link_clk,
   output logic link_sel_n,
   output logic link_data
);
   initial begin
      link_clk = 1'h0;
      link_sel_n = 1'h1;
      link_data = 1'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // The clock stands still between packets. A released data line shows
   // the inverse of its last bit, so a stale bit never reads as driven.
   task automatic send_packet(input logic [31:0] pkt);
      #3;
      link_sel_n = 1'h0;
      for (int i = 31; i >= 0; i--) begin
         link_data = pkt[i];
         #40;
         link_clk = 1'h1;
         #40;
         link_clk = 1'h0;
      end
      #40;
      link_sel_n = 1'h1;
      link_data = ~pkt[0];
      #400;
   endtask : send_packet
endmodule : host_link_model

//--- verif/receiver_step_and_frame_config_bench.sv
`timescale 1ns/1ps
`include "rx_step_consts.svh"
module receiver_step_and_frame_config_bench;
   localparam int TICK = 4;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, link_clk;
   logic link_sel_n, link_data, battery_low_input, ex;
   logic receiver_control_oe_n, symbols_valid, frame_is_assigned;
   logic [7:0] s_axi_awaddr, s_axi_araddr, receiver_control_lines;
   logic [7:0] last_lines;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [6:0] frame_query;
   logic [2:0] air_collapse;
   logic [15:0] address_word_enable;
   logic [7:0] on_val [3] = '{8'h11, 8'h5A, 8'h22};
   int failures, num_checks, run_len, prev_len;

   rx_step_config #(.TICK_CYCLES(TICK)) u_rx_step_config (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .link_clk, .link_sel_n, .link_data,
      .battery_low_input, .frame_query, .air_collapse,
      .receiver_control_lines, .receiver_control_oe_n, .symbols_valid,
      .frame_is_assigned, .address_word_enable
   );
   host_link_model u_host_link_model (.link_clk, .link_sel_n, .link_data);

   initial begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end

   // Step times are measured here, since a bus answer may land late.
   always @(posedge aclk) begin
      if (receiver_control_lines === last_lines) begin
         run_len <= run_len + 1;
      end else begin
         run_len <= 1;
         prev_len <= run_len;
      end
      last_lines <= receiver_control_lines;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report

   task automatic timed_out();
      failures++;
      final_report();
   endtask : timed_out

   task automatic check_val(input string nm, input logic [31:0] e,
         input logic [31:0] got);
      num_checks++;
      if (got !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, got);
      end
   endtask : check_val

   task automatic check_resp(input string nm, input logic [1:0] e,
         input logic [1:0] got);
      check_val(nm, 32'(e), 32'(got));
   endtask : check_resp

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] st, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      n = 0;
      while (n < 200) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) break;
         n++;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
      if (n == 200) timed_out();
   endtask : axi_write

   // A late rready checks that the answer stands until it is taken.
   task automatic axi_read(input logic [7:0] a, input int lag,
         output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= (lag == 0);
      n = 0;
      while (n < 200) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1 && s_axi_rready) break;
         if (n + 1 == lag) s_axi_rready <= 1'h1;
         n++;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
      if (n == 200) timed_out();
   endtask : axi_read

   // Waits for a line value, then checks how many cycles it was held.
   task automatic hold_time(input string nm, input logic [7:0] v,
         input int len);
      int n;
      n = 0;
      while (receiver_control_lines !== v && n < 100) begin
         @(posedge aclk);
         n++;
      end
      while (receiver_control_lines === v && n < 600) begin
         @(posedge aclk);
         n++;
      end
      if (n >= 600) timed_out();
      @(posedge aclk);
      check_val(nm, 32'h1, 32'(prev_len >= len && prev_len <= len + 1));
   endtask : hold_time

   task automatic do_reset();
      aresetn <= 1'h0;
      repeat (16) @(posedge aclk);
      check_val("oe_n_rst", 32'h1, 32'(receiver_control_oe_n));
      check_val("lines_rst", 32'h0, 32'(receiver_control_lines));
      check_val("en_rst", 32'h0, 32'(address_word_enable));
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      check_val("oe_n_run", 32'h0, 32'(receiver_control_oe_n));
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////
   initial begin
      aresetn = 1'h0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'h0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'h0;
      s_axi_bready = 1'h0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'h0;
      s_axi_rready = 1'h0;
      battery_low_input = 1'h0;
      frame_query = 7'h00;
      air_collapse = 3'h7;
      do_reset();
      axi_read(8'h40, 0, rd, rs);
      check_resp("rd_unmapped", 2'h2, rs);
      axi_write(8'h40, 32'h0000_0001, 4'hF, rs);
      check_resp("wr_unmapped", 2'h2, rs);
      u_host_link_model.send_packet(32'h7800_8001);
      check_val("en_edges", 32'h8001, 32'(address_word_enable));
      u_host_link_model.send_packet(32'h7800_0000);
      check_val("en_clear", 32'h0, 32'(address_word_enable));
      u_host_link_model.send_packet(32'h7800_A5C3);
      axi_read(`RSF_OFF_ADDR_EN, 3, rd, rs);
      check_val("en_read", 32'hA5C3, rd);
      axi_write(`RSF_OFF_PACKET, 32'h7800_FFFF, 4'h7, rs);
      check_resp("wr_part", 2'h0, rs);
      axi_read(`RSF_OFF_ADDR_EN, 0, rd, rs);
      check_val("en_keep", 32'hA5C3, rd);
      for (int k = 0; k < 8; k++) begin
         u_host_link_model.send_packet({8'(32 + k), 8'h00, 16'h0001 << k});
      end
      for (int f = 0; f < 128; f++) begin
         frame_query <= 7'(f);
         ex = (f % 16) == (7 - f / 16);
         repeat (2) @(posedge aclk);
         check_val("frame", 32'(ex), 32'(frame_is_assigned));
      end
      frame_query <= 7'h05;
      for (int c = 0; c < 2; c++) begin
         air_collapse <= 3'(c);
         repeat (2) @(posedge aclk);
         check_val("collapse", 32'h1, 32'(frame_is_assigned));
      end
      axi_write(`RSF_OFF_CONTROL, 32'h0000_0002, 4'hF, rs);
      repeat (2) @(posedge aclk);
      check_val("manual", 32'h0, 32'(frame_is_assigned));
      air_collapse <= 3'h7;
      u_host_link_model.send_packet(32'h1608_3C02);
      u_host_link_model.send_packet(32'h1700_1100);
      u_host_link_model.send_packet(32'h1800_5A00);
      u_host_link_model.send_packet(32'h1900_2200);
      u_host_link_model.send_packet(32'h1A80_773F);
      u_host_link_model.send_packet(32'h1B00_9901);
      for (int s = 0; s < 3; s++) begin
         battery_low_input <= (s != 1);
         if (s == 2)
            axi_write(`RSF_OFF_PACKET, 32'h1B80_9901, 4'hF, rs);
         axi_write(`RSF_OFF_CONTROL, {28'h0, 2'(s), 2'h1}, 4'hF, rs);
         check_resp("ctl_wr", 2'h0, rs);
         hold_time("sync", 8'h3C, 2 * TICK);
         @(posedge aclk);
         check_val("on_lines", 32'(on_val[s]), 32'(receiver_control_lines));
         check_val("sym_valid", 32'h1, 32'(symbols_valid));
         axi_read(`RSF_OFF_STATUS, 0, rd, rs);
         check_val("st_on", {27'h0, s != 1, 1'h1, rx_step_pkg::RX_ON}, rd);
         battery_low_input <= 1'h1;
         axi_write(`RSF_OFF_CONTROL, 32'h0000_0000, 4'hF, rs);
         hold_time("shut1", 8'h77, 63 * TICK);
         if (s == 2) hold_time("shut2", 8'h99, TICK);
         check_val("off_lines", 32'h0, 32'(receiver_control_lines));
         axi_read(`RSF_OFF_STATUS, 0, rd, rs);
         check_val("st_off", {27'h0, s != 1, 1'h0, rx_step_pkg::RX_OFF}, rd);
      end
      axi_write(`RSF_OFF_CONTROL, 32'h0000_0001, 4'hF, rs);
      hold_time("sync_again", 8'h3C, 2 * TICK);
      do_reset();
      final_report();
   end
endmodule : receiver_step_and_frame_config_bench
